// file: pkg/pm_pkg.sv
// Purpose: shared constants, types and helpers of the macrocell array
// Assumes: 10 MHz reference clock, APB register access
// Notes: all offsets are byte addresses of aligned 32-bit words
`default_nettype none

package pm_pkg;

  // ----------------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------------
  localparam int NIN = 12; // dedicated inputs
  localparam int NMC = 10; // input/output macrocells
  localparam int NVEC = NIN + NMC; // array input vector width
  localparam int NPT = 8; // product terms per macrocell
  localparam int NTERM = NMC * NPT + 2; // plus reset and preset terms
  localparam int TW = 2 * NVEC; // true and complement mask bits
  localparam int TW_HI = TW - 32; // mask bits in the upper word
  localparam int IDXW = 7;
  localparam logic [IDXW-1:0] AR_IDX = 7'h50; // async reset term
  localparam logic [IDXW-1:0] SP_IDX = 7'h51; // sync preset term
  localparam logic [IDXW-1:0] IDX_LAST = 7'h51;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_TIDX = 8'h04;
  localparam logic [7:0] A_TLO = 8'h08;
  localparam logic [7:0] A_THI = 8'h0C;
  localparam logic [7:0] A_PRELOAD = 8'h10;
  localparam logic [7:0] A_SECURE = 8'h14;
  localparam logic [7:0] A_SIG_LO = 8'h18;
  localparam logic [7:0] A_SIG_HI = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;
  localparam int ST_SEC_BIT = 16;
  localparam int ST_BUSY_BIT = 17;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam logic [63:0] SIG_RST = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------------
  // power-up reset timing
  // ----------------------------------------------------------------------
  localparam int PUR_NS = 1000; // power_up_reset_interval, longest
  localparam int CLK_MHZ = 10;
  localparam int PUR_CYC = (PUR_NS * CLK_MHZ) / 1000; // rounded down
  localparam int PUR_CW = 4;
  localparam logic [PUR_CW-1:0] PUR_LAST = PUR_CW'(PUR_CYC - 1);

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [NMC-1:0] oe; // output buffer enabled
    logic [NMC-1:0] act_low; // inverted output polarity
    logic [NMC-1:0] reg_en; // registered output
  } pm_cfg_s;

  typedef enum {PUR_WAIT, PUR_RUN} pm_pur_e;

  // an all-zero mask marks an unused term, which stays false
  function automatic logic pm_term_hit(input logic [TW-1:0] m,
                                       input logic [NVEC-1:0] v);
    pm_term_hit = (|m) & (&(~m[NVEC-1:0] | v)) & (&(~m[TW-1:NVEC] | ~v));
  endfunction : pm_term_hit

endpackage : pm_pkg

`default_nettype wire

// file: rtl/pm_macrocell_array.sv
// Purpose: programmable sum-of-products array with ten macrocells
// Assumes: board pins and pin clock are asynchronous to ref_clk_i
// Notes: configuration, signature, preload and security over APB
// Notes on behaviour
// RULE_01: twelve inputs, ten macrocells feed the array
// RULE_02: each cell registered/combinational, high/low polarity
// RULE_03: power-up clears all registers, lasts 1000 ns
// RULE_04: pin level follows polarity after reset clears
// RULE_05: board keeps clock still during power-up
// RULE_06: board meets setup before first clock edge
// RULE_07: async reset from array, sync preset at edge
// RULE_08: preload forces any value into each register
// RULE_09: 64-bit signature always readable and writable
// RULE_10: secured: refuse verify readback and preload
// RULE_11: security set last, it acts at once
// RULE_12: undriven pins keep their last driven level
// RULE_13: registers capture on pin clock rise, feed back
`default_nettype none

module pm_macrocell_array
  import pm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic pld_clk_i,
  input wire logic [NIN-1:0] in_i,
  input wire logic [NIN-1:0] in_drv_i,
  input wire logic [NMC-1:0] io_i,
  input wire logic [NMC-1:0] io_drv_i,
  output logic [NMC-1:0] io_o,
  output logic [NMC-1:0] io_oe_o,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  localparam int SW = NIN + NIN + NMC + NMC + 1;
  logic [SW-1:0] s1_q, s1_d, s2_q, s2_d;
  logic clk_old_q, clk_old_d;
  logic [NIN-1:0] in_keep_q, in_keep_d, in_val_s, in_drv_s;
  logic [NMC-1:0] io_keep_q, io_keep_d, io_val_s, io_drv_s;
  logic clk_s, clk_edge;
  pm_pur_e pur_q, pur_d;
  logic [PUR_CW-1:0] pur_cnt_q, pur_cnt_d;
  logic busy;
  logic [NMC-1:0] mc_q, mc_d, mc_eff, sum, pin_val, fb;
  logic [NMC-1:0] io_o_q, io_o_d;
  logic [NVEC-1:0] vec;
  logic ar_hit, sp_hit;
  logic [TW-1:0] pt_mem [NTERM];
  pm_cfg_s cfg_q, cfg_d;
  logic [IDXW-1:0] idx_q, idx_d;
  logic sec_q, sec_d;
  logic [63:0] sig_q, sig_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic setup, wr, idx_ok, pre_we, we_lo, we_hi;

  // ----------------------------------------------------------------------
  // pin synchronisers and keepers
  // ----------------------------------------------------------------------
  assign {clk_s, io_drv_s, io_val_s, in_drv_s, in_val_s} = s2_q;
  assign clk_edge = clk_s & ~clk_old_q; // rising pin clock

  // next values of the sampled pins and the held levels
  always_comb begin
    s1_d = {pld_clk_i, io_drv_i, io_i, in_drv_i, in_i};
    s2_d = s1_q;
    clk_old_d = clk_s;
    for (int k = 0; k < NIN; k++) begin
      in_keep_d[k] = in_drv_s[k] ? in_val_s[k] : in_keep_q[k]; // RULE_12
    end
    for (int k = 0; k < NMC; k++) begin
      // our own drive also counts as a driven level
      io_keep_d[k] = (io_drv_s[k] | cfg_q.oe[k]) ? io_val_s[k]
                                                 : io_keep_q[k]; // RULE_12
    end
  end

  // sync and keeper registers
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q <= '0;
      s2_q <= '0;
      clk_old_q <= 1'b0;
      in_keep_q <= '0;
      io_keep_q <= '0;
    end else if (clk_en_i) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      clk_old_q <= clk_old_d;
      in_keep_q <= in_keep_d;
      io_keep_q <= io_keep_d;
    end
  end

  // ----------------------------------------------------------------------
  // logic array
  // ----------------------------------------------------------------------
  assign fb = (cfg_q.reg_en & mc_q) | (~cfg_q.reg_en & io_keep_q); // RULE_13
  assign vec = {fb, in_keep_q}; // RULE_01
  assign ar_hit = pm_term_hit(pt_mem[AR_IDX], vec);
  assign sp_hit = pm_term_hit(pt_mem[SP_IDX], vec);

  // one sum of products per macrocell
  for (genvar c = 0; c < NMC; c++) begin : g_cell
    always_comb begin
      sum[c] = 1'b0;
      for (int t = 0; t < NPT; t++) begin
        sum[c] = sum[c] | pm_term_hit(pt_mem[c * NPT + t], vec); // RULE_01
      end
    end
  end

  // ----------------------------------------------------------------------
  // power-up reset and macrocell registers
  // ----------------------------------------------------------------------
  assign busy = (pur_q == PUR_WAIT);
  assign mc_eff = ar_hit ? '0 : mc_q; // RULE_07
  assign pin_val = (cfg_q.reg_en & mc_eff) | (~cfg_q.reg_en & sum); // RULE_02

  // next state of power-up timer, registers and pin drivers
  always_comb begin
    pur_d = pur_q;
    pur_cnt_d = pur_cnt_q;
    mc_d = mc_q;
    case (pur_q)
      PUR_WAIT: begin
        pur_cnt_d = pur_cnt_q + 1'b1;
        if (pur_cnt_q == PUR_LAST) begin
          pur_d = PUR_RUN; // RULE_03
        end
      end
      PUR_RUN: pur_d = PUR_RUN;
      default: pur_d = PUR_WAIT;
    endcase
    if (busy) begin
      mc_d = '0; // RULE_03
    end else if (ar_hit) begin
      mc_d = '0; // RULE_07
    end else if (pre_we) begin
      mc_d = pwdata_i[NMC-1:0]; // RULE_08
    end else if (clk_edge) begin
      mc_d = sp_hit ? '1 : sum; // RULE_07 RULE_13
    end
    io_o_d = pin_val ^ cfg_q.act_low; // RULE_02 RULE_04
  end

  // power-up and macrocell state
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pur_q <= PUR_WAIT;
      pur_cnt_q <= '0;
      mc_q <= '0;
      io_o_q <= '0;
    end else if (clk_en_i) begin
      pur_q <= pur_d;
      pur_cnt_q <= pur_cnt_d;
      mc_q <= mc_d;
      io_o_q <= io_o_d;
    end
  end

  assign io_o = io_o_q;
  assign io_oe_o = cfg_q.oe;

  // ----------------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------------
  assign setup = psel_i & ~penable_i;
  assign wr = psel_i & penable_i & pwrite_i;
  assign pready_o = 1'b1; // zero wait states
  assign idx_ok = (idx_q <= IDX_LAST);
  assign pre_we = wr & (paddr_i == A_PRELOAD) & ~sec_q; // RULE_10
  assign we_lo = wr & (paddr_i == A_TLO) & idx_ok;
  assign we_hi = wr & (paddr_i == A_THI) & idx_ok;

  // register writes in the access cycle, read data prepared in the setup cycle
  always_comb begin
    cfg_d = cfg_q;
    idx_d = idx_q;
    sec_d = sec_q;
    sig_d = sig_q;
    rdata_d = rdata_q;
    err_d = err_q;
    if (wr) begin
      case (paddr_i)
        A_CFG: cfg_d = pwdata_i[$bits(pm_cfg_s)-1:0];
        A_TIDX: idx_d = pwdata_i[IDXW-1:0];
        A_SECURE: sec_d = sec_q | pwdata_i[0]; // RULE_10
        A_SIG_LO: sig_d[31:0] = pwdata_i; // RULE_09
        A_SIG_HI: sig_d[63:32] = pwdata_i; // RULE_09
        default: sec_d = sec_q;
      endcase
    end
    if (setup) begin
      rdata_d = RD_ZERO;
      err_d = 1'b0;
      case (paddr_i)
        A_CFG: rdata_d = 32'(cfg_q);
        A_TIDX: rdata_d = 32'(idx_q);
        A_TLO: begin
          err_d = ~idx_ok;
          if (!sec_q && idx_ok && !pwrite_i) begin
            rdata_d = pt_mem[idx_q][31:0]; // RULE_10
          end
        end
        A_THI: begin
          err_d = ~idx_ok;
          if (!sec_q && idx_ok && !pwrite_i) begin
            rdata_d = 32'(pt_mem[idx_q][TW-1:32]); // RULE_10
          end
        end
        A_PRELOAD: err_d = sec_q & pwrite_i; // RULE_10
        A_SECURE: rdata_d = 32'(sec_q);
        A_SIG_LO: rdata_d = sig_q[31:0]; // RULE_09
        A_SIG_HI: rdata_d = sig_q[63:32]; // RULE_09
        A_STATUS: begin
          rdata_d = 32'(mc_q);
          rdata_d[ST_SEC_BIT] = sec_q;
          rdata_d[ST_BUSY_BIT] = busy;
        end
        default: err_d = 1'b1;
      endcase
    end
  end

  // control registers
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_q <= '0;
      idx_q <= '0;
      sec_q <= 1'b0;
      sig_q <= SIG_RST;
      rdata_q <= RD_ZERO;
      err_q <= 1'b0;
    end else if (clk_en_i) begin
      cfg_q <= cfg_d;
      idx_q <= idx_d;
      sec_q <= sec_d;
      sig_q <= sig_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // product-term mask store
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int t = 0; t < NTERM; t++) begin
        pt_mem[t] <= '0;
      end
    end else if (clk_en_i) begin
      if (we_lo) begin
        pt_mem[idx_q][31:0] <= pwdata_i;
      end
      if (we_hi) begin
        pt_mem[idx_q][TW-1:32] <= pwdata_i[TW_HI-1:0];
      end
    end
  end

  assign prdata_o = rdata_q;
  assign pslverr_o = err_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_pur_clear: assert property (busy |=> mc_q == '0) // RULE_03
    else $error("register not clear during power-up");
  a_pur_len: assert property (busy && clk_en_i &&
      pur_cnt_q == PUR_LAST |=> !busy) // RULE_03
    else $error("power-up interval length wrong");
  a_pin_pol: assert property (clk_en_i |=>
      io_o == ($past(pin_val) ^ $past(cfg_q.act_low))) // RULE_04
    else $error("pin level ignores polarity");
  a_async_clr: assert property (clk_en_i && ar_hit |=> mc_q == '0) // RULE_07
    else $error("async reset did not clear register");
  a_sync_pre: assert property (clk_en_i && !busy && !ar_hit && !pre_we &&
      clk_edge && sp_hit |=> mc_q == '1) // RULE_07
    else $error("sync preset missed");
  a_edge_cap: assert property (clk_en_i && !busy && !ar_hit && !pre_we &&
      clk_edge && !sp_hit |=> mc_q == $past(sum)) // RULE_13
    else $error("edge capture wrong");
  a_hold_idle: assert property (clk_en_i && !busy && !ar_hit && !pre_we &&
      !clk_edge |=> $stable(mc_q)) // RULE_13
    else $error("register moved without edge");
  a_preload_val: assert property (clk_en_i && !busy && !ar_hit &&
      pre_we |=> mc_q == $past(pwdata_i[NMC-1:0])) // RULE_08
    else $error("preload value not taken");
  a_sec_verify: assert property (clk_en_i && sec_q && setup &&
      (paddr_i == A_TLO || paddr_i == A_THI) |=> prdata_o == '0) // RULE_10
    else $error("verify readback while secured");
  a_sig_write: assert property (clk_en_i && wr &&
      paddr_i == A_SIG_LO |=> sig_q[31:0] == $past(pwdata_i)) // RULE_09
    else $error("signature write lost");
  a_keep_in: assert property (clk_en_i && !in_drv_s[0] |=>
      in_keep_q[0] == $past(in_keep_q[0])) // RULE_12
    else $error("keeper lost level");

endmodule : pm_macrocell_array

`default_nettype wire

// file: verif/pm_board.sv
// Purpose: board logic model driving the array's pins and pin clock
// Assumes: pin clock stands still between pulses
// Notes: a released pin shows the inverse of its last driven level
`default_nettype none

module pm_board
  import pm_pkg::*;
(
  input wire logic clk_i,
  input wire logic [NMC-1:0] cell_i,
  input wire logic [NMC-1:0] cell_oe_i,
  output logic pld_clk_o,
  output logic [NIN-1:0] in_o,
  output logic [NIN-1:0] in_drv_o,
  output logic [NMC-1:0] io_o,
  output logic [NMC-1:0] io_drv_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NIN-1:0] in_val;
  logic [NMC-1:0] io_val;

  // released lines flip so a kept level cannot pass by luck
  assign in_o = in_val ^ ~in_drv_o;
  assign io_o = (cell_oe_i & cell_i) | (~cell_oe_i & (io_val ^ ~io_drv_o));

  // clock pin idles low, pins start driven low
  initial begin
    pld_clk_o = 1'b0;
    in_val = '0;
    in_drv_o = '1;
    io_val = '0;
    io_drv_o = '1;
  end

  // drive levels; released bits keep the last driven value
  task automatic drive(input logic [NIN-1:0] v, input logic [NIN-1:0] d);
    @(posedge clk_i);
    in_val <= (v & d) | (in_val & ~d);
    in_drv_o <= d;
  endtask : drive

  // one pin clock pulse with setup margin on both sides
  task automatic clk_pulse();
    repeat (4) @(posedge clk_i);
    pld_clk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    pld_clk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : clk_pulse
endmodule : pm_board

`default_nettype wire

// file: verif/test_pm_macrocell_array.sv
// Purpose: self-checking bench of the macrocell array
// Assumes: zero wait state APB, board model on the pin side
// Notes: waits follow the two-cycle pin sync and registered outputs
`default_nettype none

`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  miscompares++; $display("ERROR %s exp %h seen %h", n, e, g); end end

module test_pm_macrocell_array
  import pm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, er, pclk;
  logic clk_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NIN-1:0] pin, pdrv;
  logic [NMC-1:0] io_i, io_drv, io_o, io_oe;
  int miscompares, n_tests, cyc_n;

  // ----------------------------------------------------------------------
  // design and board
  // ----------------------------------------------------------------------
  pm_macrocell_array i_pm_macrocell_array (.ref_clk_i(clk), .rst_b_i(rst_b),
    .clk_en_i(clk_en), .pld_clk_i(pclk), .in_i(pin), .in_drv_i(pdrv),
    .io_i(io_i), .io_drv_i(io_drv), .io_o(io_o), .io_oe_o(io_oe),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr));
  pm_board i_pm_board (.clk_i(clk), .cell_i(io_o), .cell_oe_i(io_oe),
    .pld_clk_o(pclk), .in_o(pin), .in_drv_o(pdrv), .io_o(io_i),
    .io_drv_o(io_drv));

  // ----------------------------------------------------------------------
  // bus and helpers
  // ----------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // pready is tied high, so this wait ends at once
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic chk_rd(input string s, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(s, e, rd & m)
  endtask : chk_rd

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_powerup();
    wr(A_PRELOAD, 32'h0000_03FF);
    chk_rd("busy", A_STATUS, 32'h0002_03FF, 32'h0002_0000);
    repeat (12) @(posedge clk);
    chk_rd("idle", A_STATUS, 32'h0002_03FF, 32'h0000_0000);
    chk_rd("sig", A_SIG_LO, 32'hFFFF_FFFF, SIG_RST[31:0]);
    `CHK("io_o", 10'h000, io_o)
  endtask : t_powerup

  task automatic t_comb();
    wr(A_TIDX, 32'h0000_0000);
    wr(A_TLO, 32'h0000_0001);
    wr(A_CFG, 32'h0010_0000);
    i_pm_board.drive(12'h001, 12'hFFF);
    repeat (6) @(posedge clk);
    `CHK("comb hi", 1'b1, io_o[0])
    `CHK("oe", 10'h001, io_oe)
    wr(A_CFG, 32'h0010_0400);
    repeat (4) @(posedge clk);
    `CHK("comb lo", 1'b0, io_o[0])
    i_pm_board.drive(12'h000, 12'hFFE);
    repeat (6) @(posedge clk);
    `CHK("keeper", 1'b0, io_o[0])
    i_pm_board.drive(12'h000, 12'hFFF);
  endtask : t_comb

  task automatic t_reg();
    wr(A_CFG, 32'h0000_0802);
    repeat (4) @(posedge clk);
    `CHK("pol", 1'b1, io_o[1])
    wr(A_TIDX, 32'h0000_0008);
    wr(A_TLO, 32'h0000_0002);
    i_pm_board.drive(12'h002, 12'hFFF);
    i_pm_board.clk_pulse();
    chk_rd("clk", A_STATUS, 32'h0000_03FF, 32'h0000_0002);
    `CHK("reg out", 1'b0, io_o[1])
    wr(A_TIDX, 32'h0000_0050);
    wr(A_TLO, 32'h0000_0004);
    i_pm_board.drive(12'h006, 12'hFFF);
    repeat (6) @(posedge clk);
    chk_rd("areset", A_STATUS, 32'h0000_03FF, 32'h0000_0000);
    i_pm_board.drive(12'h00A, 12'hFFF);
    wr(A_TIDX, 32'h0000_0051);
    wr(A_TLO, 32'h0000_0008);
    i_pm_board.clk_pulse();
    chk_rd("preset", A_STATUS, 32'h0000_03FF, 32'h0000_03FF);
    i_pm_board.drive(12'h002, 12'hFFF);
    wr(A_PRELOAD, 32'h0000_0155);
    chk_rd("pre a", A_STATUS, 32'h0000_03FF, 32'h0000_0155);
    wr(A_PRELOAD, 32'h0000_02AA);
    chk_rd("pre b", A_STATUS, 32'h0000_03FF, 32'h0000_02AA);
  endtask : t_reg

  task automatic t_secure();
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK("unmapped", 1'b1, er)
    wr(A_TIDX, 32'h0000_0052);
    wr(A_TLO, 32'h0000_0001);
    `CHK("bad index", 1'b1, er)
    wr(A_TIDX, 32'h0000_0008);
    chk_rd("verify", A_TLO, 32'hFFFF_FFFF, 32'h0000_0002);
    // security goes on after the last pattern write
    wr(A_SECURE, 32'h0000_0001);
    chk_rd("sec", A_STATUS, 32'h0001_0000, 32'h0001_0000);
    chk_rd("no verify", A_TLO, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(A_PRELOAD, 32'h0000_0055);
    `CHK("pre err", 1'b1, er)
    chk_rd("no pre", A_STATUS, 32'h0000_03FF, 32'h0000_02AA);
    wr(A_SIG_HI, 32'hA5A5_0F0F);
    chk_rd("sig", A_SIG_HI, 32'hFFFF_FFFF, 32'hA5A5_0F0F);
  endtask : t_secure

  // a write while the clock enable is low must not land
  task automatic t_freeze();
    @(posedge clk);
    clk_en <= 1'b0;
    wr(A_SIG_LO, 32'h5A5A_C3C3);
    @(posedge clk);
    clk_en <= 1'b1;
    chk_rd("frozen", A_SIG_LO, 32'hFFFF_FFFF, SIG_RST[31:0]);
    wr(A_SIG_LO, 32'h5A5A_C3C3);
    chk_rd("thawed", A_SIG_LO, 32'hFFFF_FFFF, 32'h5A5A_C3C3);
  endtask : t_freeze

  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      miscompares++;
      final_report();
    end
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_powerup();
    t_comb();
    t_reg();
    t_secure();
    t_freeze();
    final_report();
  end
endmodule : test_pm_macrocell_array

`default_nettype wire
